// ==== design/wwdt_top.sv ====
// windowed watchdog timer: prescaler, postscaler, window check, flags
// assumes cpu events are one-cycle pulses synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_map.svh"
module wwdt_top (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    // configuration word
    input  wire wwdt_pkg::wwdt_cfg_t  cfg_i,
    // cpu events
    input  wire wwdt_pkg::wwdt_evt_t  evt_i,
    input  wire logic                 power_save_idle_i,
    // software enable writes
    input  wire logic                 sw_enable_set_i,
    input  wire logic                 sw_enable_clr_i,
    // flag clears from software
    input  wire logic                 timeout_flag_clr_i,
    input  wire logic                 sleep_flag_clr_i,
    input  wire logic                 idle_flag_clr_i,
    // status
    output logic                      sw_watchdog_enable_o,
    output logic                      watchdog_timeout_flag_o,
    output logic                      sleep_flag_o,
    output logic                      idle_flag_o,
    output logic                      osc_enable_o,
    output logic                      wake_o,
    output logic                      device_reset_o,
    output logic [`WWDT_POST_W-1:0]   post_count_o
);
    logic                     running;
    logic                     rc_tick;
    logic                     restart;
    logic                     pre_end;
    logic                     post_end;
    logic                     timeout;
    logic                     early_clear;
    logic [6:0]               pre_count;
    logic [6:0]               next_pre_count;
    logic [`WWDT_POST_W-1:0]  post_count;
    logic [`WWDT_POST_W-1:0]  next_post_count;
    logic [`WWDT_POST_W-1:0]  post_last;
    logic [`WWDT_POST_W-1:0]  win_open;
    wwdt_pkg::wwdt_mode_t     mode;
    wwdt_pkg::wwdt_mode_t     next_mode;
    logic                     sw_en;
    logic                     next_sw_en;
    logic                     to_flag;
    logic                     next_to_flag;
    logic                     slp_flag;
    logic                     next_slp_flag;
    logic                     idl_flag;
    logic                     next_idl_flag;
    logic                     wake;
    logic                     next_wake;
    logic                     dev_rst;
    logic                     next_dev_rst;

    // postscale ratio 2^sel, returned as the last count value
    function automatic logic [`WWDT_POST_W-1:0] post_limit(input logic [3:0] sel);
        logic [`WWDT_POST_W:0] one_hot;
        one_hot = '0;
        one_hot[sel] = 1'b1;
        post_limit = one_hot[`WWDT_POST_W-1:0] - `WWDT_POST_W'(1);
        if (sel == 4'hf) begin
            post_limit = '1;
        end
    endfunction

    assign running  = cfg_i.hw_watchdog_enable || sw_en;
    assign restart  = evt_i.osc_switch_done || evt_i.power_save_instr
                   || evt_i.wake_exit || evt_i.clear_watchdog_instr || !running;
    assign pre_end  = pre_count == (cfg_i.prescale_select ? `WWDT_PRE_LONG_MAX
                                                          : `WWDT_PRE_SHORT_MAX);
    assign post_last = post_limit(cfg_i.postscale_select);
    assign post_end = post_count == post_last;
    assign timeout  = running && !restart && rc_tick && pre_end && post_end;
    // window opens for the last 5/8 .. 3/16 of the period, by the 2-bit select
    // shift is widened so select 3 gives a shift of 4 instead of wrapping to 0
    assign win_open = post_last - (post_last >> ({1'b0, cfg_i.window_select} + 3'h1)) - (post_last >> 3);
    assign early_clear = running && evt_i.clear_watchdog_instr && mode == wwdt_pkg::WWDT_RUN
                      && !cfg_i.window_disable && post_count < win_open;

    wwdt_rc_osc u_osc (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .enable_i (running),
        .tick_o   (rc_tick)
    );

    always_comb begin
        next_pre_count  = pre_count;
        next_post_count = post_count;
        if (restart) begin
            next_pre_count  = '0;
            next_post_count = '0;
        end else if (rc_tick) begin
            next_pre_count = pre_end ? 7'h00 : pre_count + 7'h01;
            if (pre_end) begin
                next_post_count = post_end ? '0 : post_count + `WWDT_POST_W'(1);
            end
        end
    end

    always_comb begin
        next_mode     = mode;
        next_sw_en    = sw_en;
        next_to_flag  = to_flag;
        next_slp_flag = slp_flag;
        next_idl_flag = idl_flag;
        next_wake     = 1'b0;
        next_dev_rst  = 1'b0;
        if (sw_enable_clr_i) next_sw_en = 1'b0;
        if (sw_enable_set_i) next_sw_en = 1'b1;
        if (timeout_flag_clr_i) next_to_flag = 1'b0;
        if (sleep_flag_clr_i) next_slp_flag = 1'b0;
        if (idle_flag_clr_i) next_idl_flag = 1'b0;
        case (mode)
            wwdt_pkg::WWDT_RUN: begin
                if (evt_i.power_save_instr) begin
                    next_mode = power_save_idle_i ? wwdt_pkg::WWDT_IDLE : wwdt_pkg::WWDT_SLEEP;
                    if (power_save_idle_i) next_idl_flag = 1'b1;
                    else next_slp_flag = 1'b1;
                end
                if (timeout || early_clear) next_dev_rst = 1'b1;
            end
            wwdt_pkg::WWDT_SLEEP, wwdt_pkg::WWDT_IDLE: begin
                if (evt_i.wake_exit) next_mode = wwdt_pkg::WWDT_RUN;
                if (timeout) begin
                    next_mode = wwdt_pkg::WWDT_RUN;
                    next_wake = 1'b1;
                end
            end
            default: next_mode = wwdt_pkg::WWDT_RUN;
        endcase
        if (timeout) next_to_flag = 1'b1;
        if (next_dev_rst) next_sw_en = 1'b0;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pre_count  <= '0;
            post_count <= '0;
            mode       <= wwdt_pkg::WWDT_RUN;
            sw_en      <= 1'b0;
            to_flag    <= 1'b0;
            slp_flag   <= 1'b0;
            idl_flag   <= 1'b0;
            wake       <= 1'b0;
            dev_rst    <= 1'b0;
        end else begin
            pre_count  <= next_pre_count;
            post_count <= next_post_count;
            mode       <= next_mode;
            sw_en      <= next_sw_en;
            to_flag    <= next_to_flag;
            slp_flag   <= next_slp_flag;
            idl_flag   <= next_idl_flag;
            wake       <= next_wake;
            dev_rst    <= next_dev_rst;
        end
    end

    assign sw_watchdog_enable_o    = sw_en;
    assign watchdog_timeout_flag_o = to_flag;
    assign sleep_flag_o            = slp_flag;
    assign idle_flag_o             = idl_flag;
    assign osc_enable_o            = running;
    assign wake_o                  = wake;
    assign device_reset_o          = dev_rst;
    assign post_count_o            = post_count;
endmodule // wwdt_top
`default_nettype wire

// ==== shared/wwdt_map.svh ====
// constants for the windowed watchdog: config word fields, divider widths, timing
// assumes inclusion by the package and the design files
`ifndef WWDT_MAP_SVH
`define WWDT_MAP_SVH
`define WWDT_CFG_POST_LSB   0
`define WWDT_CFG_POST_MSB   3
`define WWDT_CFG_PRE_BIT    4
`define WWDT_CFG_WINDOW_DISABLE_BIT 6
`define WWDT_CFG_HWEN_BIT   7
`define WWDT_CFG_WIN_LSB    8
`define WWDT_CFG_WIN_MSB    9
`define WWDT_PRE_SHORT_MAX  7'h1f
`define WWDT_PRE_LONG_MAX   7'h7f
`define WWDT_POST_W         15
`define WWDT_OSC_HZ         32000
`define WWDT_CLK_HZ         40000000
`define WWDT_RC_TICK_CYC    (`WWDT_CLK_HZ / `WWDT_OSC_HZ)
`define WWDT_TICK_W         11
`endif

// ==== shared/wwdt_pkg.sv ====
// types for the windowed watchdog
// assumes wwdt_map.svh is on the include path
`include "wwdt_map.svh"
package wwdt_pkg;
    typedef struct packed {
        logic [1:0] window_select;
        logic       hw_watchdog_enable;
        logic       window_disable;
        logic       spare;
        logic       prescale_select;
        logic [3:0] postscale_select;
    } wwdt_cfg_t;

    typedef struct packed {
        logic power_save_instr;
        logic clear_watchdog_instr;
        logic osc_switch_done;
        logic wake_exit;
    } wwdt_evt_t;

    typedef enum logic [1:0] {WWDT_RUN, WWDT_SLEEP, WWDT_IDLE} wwdt_mode_t;
endpackage

// ==== design/wwdt_rc_osc.sv ====
// low-power rc oscillator model: one-cycle tick at 32 kHz when enabled
// assumes clk_i at 40 MHz
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_map.svh"
module wwdt_rc_osc (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // control
    input  wire logic enable_i,
    // tick
    output logic      tick_o
);
    localparam logic [`WWDT_TICK_W-1:0] TICK_LAST = `WWDT_TICK_W'(`WWDT_RC_TICK_CYC - 1);
    logic [`WWDT_TICK_W-1:0] count;
    logic [`WWDT_TICK_W-1:0] next_count;

    always_comb begin
        next_count = '0;
        if (enable_i && count != TICK_LAST) begin
            next_count = count + `WWDT_TICK_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign tick_o = enable_i && count == TICK_LAST;
endmodule // wwdt_rc_osc
`default_nettype wire

// ==== verification/wwdt_top_assertions.sv ====
// checker for wwdt_top, bound to every instance of it
// assumes the port names of wwdt_top and the types of wwdt_pkg
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_map.svh"
module wwdt_top_assertions (
    // clock and reset
    input wire logic                    clk_i,
    input wire logic                    reset_i,
    // inputs
    input wire wwdt_pkg::wwdt_cfg_t     cfg_i,
    input wire wwdt_pkg::wwdt_evt_t     evt_i,
    input wire logic                    timeout_flag_clr_i,
    input wire logic                    sleep_flag_clr_i,
    // outputs
    input wire logic                    sw_watchdog_enable_o,
    input wire logic                    watchdog_timeout_flag_o,
    input wire logic                    sleep_flag_o,
    input wire logic                    osc_enable_o,
    input wire logic                    wake_o,
    input wire logic                    device_reset_o,
    input wire logic [`WWDT_POST_W-1:0] post_count_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_osc_follows_enable:
        assert property (osc_enable_o == (cfg_i.hw_watchdog_enable | sw_watchdog_enable_o))
        else $error("osc enable differs from the enables");
    chk_idle_count_zero:
        assert property (!osc_enable_o ##1 !osc_enable_o |-> post_count_o == '0)
        else $error("count moves while stopped");
    chk_switch_restart:
        assert property (evt_i.osc_switch_done |=> post_count_o == '0) else $error("switch kept count");
    chk_power_restart:
        assert property (evt_i.power_save_instr || evt_i.wake_exit |=> post_count_o == '0)
        else $error("power save kept count");
    chk_clear_restart:
        assert property (evt_i.clear_watchdog_instr |=> post_count_o == '0) else $error("clear kept count");
    chk_wake_pulse:
        assert property (wake_o |=> !wake_o) else $error("wake longer than one cycle");
    chk_reset_pulse:
        assert property (device_reset_o |-> !sw_watchdog_enable_o ##1 !device_reset_o)
        else $error("reset pulse or sw enable wrong");
    chk_timeout_sticky:
        assert property (watchdog_timeout_flag_o && !timeout_flag_clr_i |=> watchdog_timeout_flag_o)
        else $error("timeout flag dropped");
    chk_sleep_sticky:
        assert property (sleep_flag_o && !sleep_flag_clr_i |=> sleep_flag_o) else $error("sleep flag dropped");
    chk_flag_cause:
        assert property ($rose(watchdog_timeout_flag_o) |-> wake_o || device_reset_o)
        else $error("flag set without time-out");
    cover property (wake_o);
    cover property (device_reset_o);
    cover property ($rose(sleep_flag_o));
endmodule // wwdt_top_assertions
bind wwdt_top wwdt_top_assertions u_chk (.clk_i, .reset_i, .cfg_i, .evt_i, .timeout_flag_clr_i,
    .sleep_flag_clr_i, .sw_watchdog_enable_o, .watchdog_timeout_flag_o, .sleep_flag_o, .osc_enable_o,
    .wake_o, .device_reset_o, .post_count_o);
`default_nettype wire

// ==== verification/wwdt_top_test.sv ====
// self-checking bench for wwdt_top: enables, window clear, sleep and run time-outs
// assumes a 40 MHz clock and an rc tick every 1250 clocks
`timescale 1ns/1ps
`default_nettype none
module wwdt_top_test;
    logic                clk_i = 1'b0;
    logic                reset_i = 1'b1;
    wwdt_pkg::wwdt_cfg_t cfg = '0;
    wwdt_pkg::wwdt_evt_t evt = '0;
    logic                idle = 1'b0;
    logic                sw_set = 1'b0;
    logic                sw_clr = 1'b0;
    logic [2:0]          fclr = '0;
    logic                sw_en, to_flag, sleep_flag, idle_flag, osc_en, wake, dev_rst;
    logic [14:0]         post_cnt;
    int                  n_fail = 0;
    int                  total_checks = 0;
    int                  n;
    // row: hw enable, set, clear, expected sw enable, expected osc enable
    logic [4:0]          rows [5] = '{5'h0b, 5'h04, 5'h0f, 5'h15, 5'h00};
    wwdt_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .cfg_i(cfg), .evt_i(evt), .power_save_idle_i(idle),
        .sw_enable_set_i(sw_set), .sw_enable_clr_i(sw_clr), .timeout_flag_clr_i(fclr[2]),
        .sleep_flag_clr_i(fclr[1]), .idle_flag_clr_i(fclr[0]), .sw_watchdog_enable_o(sw_en),
        .watchdog_timeout_flag_o(to_flag), .sleep_flag_o(sleep_flag), .idle_flag_o(idle_flag),
        .osc_enable_o(osc_en), .wake_o(wake), .device_reset_o(dev_rst), .post_count_o(post_cnt));
    always #12.5 clk_i = ~clk_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle pulses on events and software writes
    task automatic step(input logic [3:0] e, input logic [4:0] s);
        evt = e;
        {sw_set, sw_clr, fclr} = s;
        @(negedge clk_i);
        evt = '0;
        {sw_set, sw_clr, fclr} = '0;
    endtask
    task automatic wait_for(input logic w);
        n = 0;
        while (n < 45000 && (w ? wake : dev_rst) !== 1'b1) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #2500000;
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        reset_i = 1'b0;
        chk({sw_en, to_flag, sleep_flag, idle_flag, wake, dev_rst, osc_en}, 8'h00);
        foreach (rows[i]) begin
            cfg = rows[i][4] ? 10'h0c0 : 10'h040;
            step(4'h0, {rows[i][3:2], 3'h0});
            chk({sw_en, osc_en}, rows[i][1:0]);
        end
        for (int w = 1; w >= 0; w--) begin
            cfg = w ? 10'h044 : 10'h004;
            step(4'h0, 5'h10);
            step(4'h4, 5'h00);
            chk({dev_rst, sw_en}, w ? 8'h01 : 8'h02);
            @(negedge clk_i);
            chk(dev_rst, 8'h00);
        end
        cfg = 10'h0c0;
        step(4'h2, 5'h00);
        step(4'h8, 5'h00);
        chk({sleep_flag, idle_flag}, 8'h02);
        wait_for(1'b1);
        chk(n >= 38000 && n <= 41500, 8'h01);
        chk({to_flag, sleep_flag, dev_rst}, 8'h06);
        step(4'h0, 5'h06);
        chk({to_flag, sleep_flag}, 8'h00);
        step(4'h1, 5'h00);
        chk(post_cnt == 15'h0000, 8'h01);
        wait_for(1'b0);
        chk(n >= 38000 && n <= 41500, 8'h01);
        chk({to_flag, wake}, 8'h02);
        idle = 1'b1;
        step(4'h8, 5'h00);
        chk({sleep_flag, idle_flag}, 8'h01);
        step(4'h0, 5'h01);
        chk(idle_flag, 8'h00);
        finish_test();
    end
endmodule // wwdt_top_test
`default_nettype wire
